// >>> test/cpu_trap_model.sv
// cpu trap entry model
// assumes one clock; slow lengthens each service
`timescale 1ns/1ps

module cpu_trap_model
(
    // clock and reset
    input wire sys_clk,
    input wire resetn,
    // bench controls
    input wire slow,
    input wire [3:0] baseLevel,
    // trap entry
    input wire trapTake_q,
    input wire [3:0] trapPriority_q,
    output reg [3:0] cpuPriorityLevel,
    output reg trapReturn
);
    reg [4:0] svcCnt_q;

    always @(posedge sys_clk)
    begin
        trapReturn <= 1'b0;
        if (!resetn)
        begin
            svcCnt_q <= 5'h00;
            cpuPriorityLevel <= baseLevel;
        end
        else if (trapTake_q)
        begin
            cpuPriorityLevel <= trapPriority_q;
            svcCnt_q <= slow ? 5'h14 : 5'h02;
        end
        else if (svcCnt_q != 5'h00)
        begin
            svcCnt_q <= svcCnt_q - 5'h01;
            trapReturn <= svcCnt_q == 5'h01;
            cpuPriorityLevel <= svcCnt_q == 5'h01 ? baseLevel : cpuPriorityLevel;
        end
    end
endmodule

// >>> test/xperiph_irq_chk.sv
// assertions on trap entry and register bus answer timing
// assumes it is bound to the top module and sees only its ports
`timescale 1ns/1ps
`include "xperiph_irq_map.vh"

module xperiph_irq_chk
(
    // clock and reset
    input wire sys_clk,
    input wire resetn,
    // register bus
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire s_axi_bvalid,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0] s_axi_rresp,
    input wire s_axi_rvalid,
    // trap sources
    input wire softResetReq,
    input wire watchdogOverflow,
    input wire nonmaskableReq,
    input wire stackOverflow,
    input wire stackUnderflow,
    input wire illegalExtBus,
    // cpu trap entry side
    input wire [3:0] cpuPriorityLevel,
    input wire trapTake_q,
    input wire [23:0] trapVector_q,
    input wire [6:0] trapNumber_q,
    input wire [3:0] trapPriority_q,
    input wire standardIrqBlock
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    // any event that outranks class b in the same cycle
    wire hiTrap = softResetReq || watchdogOverflow || nonmaskableReq || stackOverflow
        || stackUnderflow;

    // ****************
    // trap entry
    // ****************
    a_block_rise: assert property (
        $rose(standardIrqBlock) |-> trapTake_q && trapPriority_q == `PRIO_TOP)
        else $error("block without entry");
    a_vec_num: assert property (
        trapTake_q |-> trapVector_q == {15'h0000, trapNumber_q, 2'h0})
        else $error("vector not number times 4");
    a_reset_entry: assert property (
        softResetReq || watchdogOverflow |-> ##2 (trapTake_q && trapVector_q == `VEC_RESET
        && trapNumber_q == `NUM_RESET && trapPriority_q == `PRIO_TOP))
        else $error("reset entry missing or wrong");
    // nmi taken two cycles on unless something else entered first
    a_nmi_first: assert property (
        nonmaskableReq && !standardIrqBlock && !softResetReq && !watchdogOverflow
        ##1 !trapTake_q |=> trapTake_q && trapNumber_q == `NUM_NONMASKABLE)
        else $error("nmi not first");
    a_classb_entry: assert property (
        illegalExtBus && !hiTrap && !standardIrqBlock ##1 !trapTake_q && !standardIrqBlock
        |=> trapTake_q && trapVector_q == `VEC_CLASS_B && trapPriority_q == `PRIO_TOP)
        else $error("class b entry missing or wrong");
    a_sw_prio: assert property (
        trapTake_q && trapPriority_q != `PRIO_TOP |-> trapPriority_q == $past(cpuPriorityLevel))
        else $error("software entry changed the priority");

    // ****************
    // register bus answers
    // ****************
    // write executes the cycle after both halves are held
    a_write_resp: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("write response late");
    a_read_resp: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read response late");
    a_unmapped_rd: assert property (
        s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h18
        |=> s_axi_rresp == `RESP_SLVERR && s_axi_rdata == 32'h00000000)
        else $error("unmapped read not refused");
endmodule

bind xperiph_irq_mux_and_traps xperiph_irq_chk u_xperiph_irq_chk (.*);

// >>> test/xperiph_irq_mux_and_traps_tb.sv
// self-checking bench: register bus tasks, event and trap sequences
// assumes a bound checker and the cpu model
`timescale 1ns/1ps
`include "xperiph_irq_map.vh"

module xperiph_irq_mux_and_traps_tb;
    // ****************
    // signals
    // ****************
    reg sys_clk = 1'b0;
    reg resetn = 1'b0;
    reg s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    reg s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, swTrapReq = 1'b0, slow = 1'b0;
    reg [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    reg [31:0] s_axi_wdata = 32'h0, rdat;
    reg [3:0] s_axi_wstrb = 4'hf;
    reg [13:0] ev = 14'h0;
    reg [10:0] tr = 11'h0;
    reg [6:0] swTrapNumber = 7'h00;
    reg [1:0] rsp;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire sharedVector0, sharedVector1, sharedVector2, sharedVector3;
    wire [3:0] vecs = {sharedVector3, sharedVector2, sharedVector1, sharedVector0};
    wire trapTake_q, standardIrqBlock, irq, trapReturn;
    wire [23:0] trapVector_q;
    wire [6:0] trapNumber_q;
    wire [3:0] trapPriority_q, cpuPriorityLevel;
    int mismatches = 0, totalChecks = 0;
    // flag bytes {v3,v2,v1,v0} expected per event bit
    reg [31:0] evMap [0:13] = '{32'h01000001, 32'h02000100, 32'h00020202, 32'h00040404,
        32'h04000000, 32'h00080808, 32'h00101010, 32'h08000000, 32'h00202020,
        32'h00404040, 32'h00808080, 32'h10000000, 32'h20000000, 32'h40010000};
    reg [23:0] trVec [0:4] = '{`VEC_STACK_UNDER, `VEC_STACK_OVER, `VEC_NONMASKABLE,
        `VEC_RESET, `VEC_CLASS_B};

    always #25 sys_clk = ~sys_clk;

    // design and cpu model
    xperiph_irq_mux_and_traps u_xperiph_irq_mux_and_traps (.*,
        .firstCanNode(ev[0]), .secondCanNode(ev[1]), .i2cReceive(ev[2]),
        .i2cTransmit(ev[3]), .i2cError(ev[4]), .secondSyncSerialRx(ev[5]),
        .secondSyncSerialTx(ev[6]), .secondSyncSerialErr(ev[7]),
        .secondAsyncSerialRx(ev[8]), .secondAsyncSerialTx(ev[9]),
        .secondAsyncSerialTxBuf(ev[10]), .secondAsyncSerialErr(ev[11]),
        .pllUnlockOscWatchdog(ev[12]), .secondPwmUnit(ev[13]),
        .illegalExtBus(tr[0]), .illegalInstrAccess(tr[1]), .illegalOperand(tr[2]),
        .protectedInstrFault(tr[3]), .macInterruption(tr[4]), .undefinedOpcode(tr[5]),
        .stackUnderflow(tr[6]), .stackOverflow(tr[7]), .nonmaskableReq(tr[8]),
        .softResetReq(tr[9]), .watchdogOverflow(tr[10]));
    cpu_trap_model u_cpu_trap_model (.*, .baseLevel(4'h5));

    // ****************
    // tasks
    // ****************
    task report_and_stop;
    begin
        $display("checks %0d mismatches %0d", totalChecks, mismatches);
        if (mismatches == 0 && totalChecks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    end
    endtask

    task chk(input [31:0] got, input [31:0] exp);
    begin
        totalChecks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    end
    endtask

    // one bus access, bounded wait
    task bus(input bit wr, input [7:0] a, input [31:0] d);
        int n;
        bit ta, tw, tk, tb;
    begin
        @(posedge sys_clk);
        s_axi_awaddr <= a;
        s_axi_araddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= wr;
        s_axi_wvalid <= wr;
        s_axi_bready <= wr;
        s_axi_arvalid <= !wr;
        s_axi_rready <= !wr;
        n = 0;
        tb = 1'b0;
        while (!tb && n < 50)
        begin
            @(negedge sys_clk);
            ta = s_axi_awvalid && s_axi_awready;
            tw = s_axi_wvalid && s_axi_wready;
            tk = s_axi_arvalid && s_axi_arready;
            tb = (s_axi_bready && s_axi_bvalid) || (s_axi_rready && s_axi_rvalid);
            rsp = wr ? s_axi_bresp : s_axi_rresp;
            rdat = s_axi_rdata;
            @(posedge sys_clk);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
            if (tk) s_axi_arvalid <= 1'b0;
            n++;
        end
        s_axi_bready <= 1'b0;
        s_axi_rready <= 1'b0;
        if (!tb)
        begin
            mismatches++;
            report_and_stop;
        end
    end
    endtask

    // await one trap entry and check it
    task take(input [23:0] v, input [6:0] nm, input [3:0] p);
        int n;
    begin
        n = 0;
        do
        begin
            @(negedge sys_clk);
            n++;
        end while (trapTake_q !== 1'b1 && n < 60);
        if (n == 60)
        begin
            mismatches++;
            report_and_stop;
        end
        chk(trapVector_q, v);
        chk(trapNumber_q, nm);
        chk(trapPriority_q, p);
        chk(standardIrqBlock, p == 4'hf);
        @(posedge sys_clk);
    end
    endtask

    // ****************
    // sequence
    // ****************
    initial
    begin
        int j;
        repeat (20) @(posedge sys_clk);
        resetn <= 1'b1;
        for (bit [7:0] a = 8'h00; a <= 8'h18; a += 8'h04)
        begin
            bus(1'b0, a, 32'h0);
            chk(rdat, 32'h0);
        end
        bus(1'b0, 8'h1c, 32'h0);
        chk(rsp, `RESP_SLVERR);
        bus(1'b1, 8'h40, 32'hffff);
        chk(rsp, `RESP_SLVERR);
        // each event alone, flags polled
        for (int k = 0; k < 14; k++)
        begin
            @(posedge sys_clk);
            ev <= 14'h1 << k;
            @(posedge sys_clk);
            ev <= 14'h0;
            for (bit [7:0] a = 8'h00; a < 8'h10; a += 8'h04)
            begin
                bus(1'b0, a, 32'h0);
                chk(rdat, evMap[k][a * 2 +: 8]);
                bus(1'b1, a, 32'h0);
            end
            chk(vecs, 32'h0);
        end
        // vector 0 enable, mask and clear
        bus(1'b1, `SEL0_OFFSET, 32'h0200);
        @(posedge sys_clk);
        ev <= 14'h0005;
        @(posedge sys_clk);
        ev <= 14'h0;
        bus(1'b0, `SEL0_OFFSET, 32'h0);
        chk(rdat, 32'h0203);
        chk(vecs, 32'h1);
        chk(irq, 32'h0);
        bus(1'b1, `IRQ_MASK_OFFSET, 32'h1);
        chk(irq, 32'h1);
        bus(1'b1, `SEL0_OFFSET, 32'h02fd);
        bus(1'b0, `SEL0_OFFSET, 32'h0);
        chk(rdat, 32'h0201);
        bus(1'b1, `IRQ_STATUS_OFFSET, 32'hf);
        chk(irq, 32'h0);
        chk(sharedVector0, 32'h0);
        // each trap source alone, prompt cpu
        for (int k = 0; k < 11; k++)
        begin
            j = k < 6 ? 4 : k > 8 ? 3 : k - 6;
            @(posedge sys_clk);
            tr <= 11'h1 << k;
            @(posedge sys_clk);
            tr <= 11'h0;
            take(trVec[j], trVec[j][8:2], 4'hf);
            bus(1'b0, `TRAP_FLAG_OFFSET, 32'h0);
            chk(rdat, k < 6 ? 1 << k : k < 9 ? 1 << (k + 7) : 0);
            bus(1'b1, `TRAP_FLAG_OFFSET, 32'h0);
        end
        // four at once, slow cpu
        slow <= 1'b1;
        @(posedge sys_clk);
        tr <= 11'h1c1;
        @(posedge sys_clk);
        tr <= 11'h0;
        for (j = 2; j >= 0; j--)
            take(trVec[j], trVec[j][8:2], 4'hf);
        take(`VEC_CLASS_B, `NUM_CLASS_B, 4'hf);
        bus(1'b0, `TRAP_FLAG_OFFSET, 32'h0);
        chk(rdat, 32'he001);
        bus(1'b1, `TRAP_FLAG_OFFSET, 32'h0);
        for (j = 0; j < 40 && standardIrqBlock !== 1'b0; j++)
            @(negedge sys_clk);
        chk(standardIrqBlock, 32'h0);
        // software trap numbers 1 and 127
        for (int n = 1; n < 128; n += 126)
        begin
            @(posedge sys_clk);
            swTrapNumber <= n[6:0];
            swTrapReq <= 1'b1;
            @(posedge sys_clk);
            swTrapReq <= 1'b0;
            take({15'h0, n[6:0], 2'h0}, n[6:0], 4'h5);
        end
        report_and_stop;
    end
endmodule

// >>> verilog/xperiph_irq_map.vh
// register map, field positions, reset values and trap table constants
// assumes inclusion by bare name from the design file
`ifndef XPERIPH_IRQ_MAP_VH
`define XPERIPH_IRQ_MAP_VH

// ****************
// register byte offsets
// ****************
`define SEL0_OFFSET 8'h00
`define SEL1_OFFSET 8'h04
`define SEL2_OFFSET 8'h08
`define SEL3_OFFSET 8'h0c
`define TRAP_FLAG_OFFSET 8'h10
`define IRQ_STATUS_OFFSET 8'h14
`define IRQ_MASK_OFFSET 8'h18

// ****************
// select register fields and reset values
// ****************
`define SEL_EN_HI 15
`define SEL_EN_LO 8
`define SEL_FLAG_HI 7
`define SEL_FLAG_LO 0
`define SEL_RESET 16'h0000

// ****************
// trap flag register bit positions
// ****************
`define TF_ILL_BUS 0
`define TF_ILL_INSTR 1
`define TF_ILL_OPERAND 2
`define TF_PROT_FAULT 3
`define TF_MAC_INT 4
`define TF_UNDEF_OPC 5
`define TF_STACK_UNDER 13
`define TF_STACK_OVER 14
`define TF_NONMASKABLE 15
`define TF_CLASS_B_MASK 16'h003f
`define TF_RESET 16'h0000

// ****************
// trap vectors, numbers and priorities
// ****************
`define VEC_RESET 24'h000000
`define VEC_NONMASKABLE 24'h000008
`define VEC_STACK_OVER 24'h000010
`define VEC_STACK_UNDER 24'h000018
`define VEC_CLASS_B 24'h000028
`define NUM_RESET 7'h00
`define NUM_NONMASKABLE 7'h02
`define NUM_STACK_OVER 7'h04
`define NUM_STACK_UNDER 7'h06
`define NUM_CLASS_B 7'h0a
`define PRIO_TOP 4'hf
`define LVL_NONE 2'h0
`define LVL_CLASS_B 2'h1
`define LVL_CLASS_A 2'h2
`define LVL_RESET 2'h3

// ************************************************
// bus responses
// ************************************************
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// >>> verilog/xperiph_irq_mux_and_traps.v
// shared extension interrupt multiplexer with trap entry arbitration
// assumes source events are one-cycle pulses from logic on sys_clk,
// and an AXI4-Lite master that keeps one write and one read in flight
//
// Operation
// RULE_01 - four shared vectors, each 16-bit select: enables high byte, flags low byte
// RULE_02 - a vector requests only from flags whose enable bit is set
// RULE_03 - events set their flag even while the enable bit is clear
// RULE_04 - software reads the flag byte to find which sources requested
// RULE_05 - i2c, sync and async serial rx/tx events reach vectors zero to two
// RULE_06 - errors, pll/watchdog, both can nodes and pwm reach vector three
// RULE_07 - all resets enter vector zero, trap number zero, highest priority
// RULE_08 - class A traps use own vectors 08h, 10h, 18h and numbers
// RULE_09 - class B traps share vector 28h, number 0Ah, below class A
// RULE_10 - each class B condition sets its own distinct trap flag
// RULE_11 - software trap reaches vectors 0 to 1FCh step 4, keeps priority
// RULE_12 - reset and hardware trap service force cpu priority to 15
// RULE_13 - hardware traps unmaskable, flagged, and block standard interrupts
// RULE_14 - nonmaskable beats stack overflow, which beats stack underflow
// RULE_15 - select flags stay set until written zero; all reset to zero
`timescale 1ns/1ps
`include "xperiph_irq_map.vh"

module xperiph_irq_mux_and_traps
(
    // clock and reset
    input wire sys_clk,
    input wire resetn,
    // axi4-lite write address and data
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    // axi4-lite write response
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // axi4-lite read
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // extension peripheral events
    input wire firstCanNode,
    input wire secondCanNode,
    input wire i2cReceive,
    input wire i2cTransmit,
    input wire i2cError,
    input wire secondSyncSerialRx,
    input wire secondSyncSerialTx,
    input wire secondSyncSerialErr,
    input wire secondAsyncSerialRx,
    input wire secondAsyncSerialTx,
    input wire secondAsyncSerialTxBuf,
    input wire secondAsyncSerialErr,
    input wire pllUnlockOscWatchdog,
    input wire secondPwmUnit,
    // shared vector requests to the cpu
    output wire sharedVector0,
    output wire sharedVector1,
    output wire sharedVector2,
    output wire sharedVector3,
    // trap sources
    input wire softResetReq,
    input wire watchdogOverflow,
    input wire nonmaskableReq,
    input wire stackOverflow,
    input wire stackUnderflow,
    input wire undefinedOpcode,
    input wire macInterruption,
    input wire protectedInstrFault,
    input wire illegalOperand,
    input wire illegalInstrAccess,
    input wire illegalExtBus,
    input wire swTrapReq,
    input wire [6:0] swTrapNumber,
    // cpu trap entry side
    input wire [3:0] cpuPriorityLevel,
    input wire trapReturn,
    output reg trapTake_q,
    output reg [23:0] trapVector_q,
    output reg [6:0] trapNumber_q,
    output reg [3:0] trapPriority_q,
    output wire standardIrqBlock,
    // interrupt to system
    output wire irq
);

    // ****************
    // bus slave
    // ****************

    // decode of a byte address into a register index, 7 is unmapped
    function [2:0] regIndex;
        input [7:0] addr;
        begin
            case (addr)
                `SEL0_OFFSET: regIndex = 3'd0;
                `SEL1_OFFSET: regIndex = 3'd1;
                `SEL2_OFFSET: regIndex = 3'd2;
                `SEL3_OFFSET: regIndex = 3'd3;
                `TRAP_FLAG_OFFSET: regIndex = 3'd4;
                `IRQ_STATUS_OFFSET: regIndex = 3'd5;
                `IRQ_MASK_OFFSET: regIndex = 3'd6;
                default: regIndex = 3'd7;
            endcase
        end
    endfunction

    reg awHeld_q;
    reg [7:0] awAddr_q;
    reg wHeld_q;
    reg [31:0] wData_q;
    reg [3:0] wStrb_q;
    wire doWrite;
    wire [2:0] wrIdx;
    wire [2:0] rdIdx;
    reg [31:0] rdMux;

    // each half is held until the other arrives; no accept while response pends
    assign s_axi_awready = !awHeld_q && !s_axi_bvalid;
    assign s_axi_wready = !wHeld_q && !s_axi_bvalid;
    assign doWrite = awHeld_q && wHeld_q;
    assign wrIdx = regIndex(awAddr_q);
    assign s_axi_arready = !s_axi_rvalid;
    assign rdIdx = regIndex(s_axi_araddr);

    // write channel capture and response
    always @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            awHeld_q <= 1'b0;
            awAddr_q <= 8'h00;
            wHeld_q <= 1'b0;
            wData_q <= 32'h00000000;
            wStrb_q <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                awHeld_q <= 1'b1;
                awAddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                wHeld_q <= 1'b1;
                wData_q <= s_axi_wdata;
                wStrb_q <= s_axi_wstrb;
            end
            if (doWrite)
            begin
                awHeld_q <= 1'b0;
                wHeld_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (wrIdx == 3'd7) ? `RESP_SLVERR : `RESP_OKAY;
            end
            else if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    // ****************
    // shared vector select registers
    // ****************

    wire [7:0] srcVec [0:3];
    wire [63:0] selFlat;
    wire [3:0] vecReq;

    // RULE_05 rx/tx sources on vectors zero to two
    assign srcVec[0] = {secondAsyncSerialTxBuf, secondAsyncSerialTx, secondAsyncSerialRx,
        secondSyncSerialTx, secondSyncSerialRx, i2cTransmit, i2cReceive, firstCanNode};
    assign srcVec[1] = {secondAsyncSerialTxBuf, secondAsyncSerialTx, secondAsyncSerialRx,
        secondSyncSerialTx, secondSyncSerialRx, i2cTransmit, i2cReceive, secondCanNode};
    assign srcVec[2] = {secondAsyncSerialTxBuf, secondAsyncSerialTx, secondAsyncSerialRx,
        secondSyncSerialTx, secondSyncSerialRx, i2cTransmit, i2cReceive, secondPwmUnit};
    // RULE_06 errors and slow sources on vector three
    assign srcVec[3] = {1'b0, secondPwmUnit, pllUnlockOscWatchdog, secondAsyncSerialErr,
        secondSyncSerialErr, i2cError, secondCanNode, firstCanNode};

    genvar v;
    generate
        for (v = 0; v < 4; v = v + 1)
        begin : gVec
            reg [7:0] enable_q;
            reg [7:0] flag_q;
            wire hit;
            wire [7:0] keep;
            wire [15:0] selRst;
            assign selRst = `SEL_RESET;
            assign hit = doWrite && (wrIdx == v);
            // writing zero clears a flag, writing one leaves it alone
            assign keep = (hit && wStrb_q[0]) ? wData_q[7:0] : 8'hff;
            // RULE_01 enable byte high, flag byte low
            // RULE_15 sticky flags, zero at reset
            always @(posedge sys_clk)
            begin
                if (!resetn)
                begin
                    enable_q <= selRst[`SEL_EN_HI:`SEL_EN_LO];
                    flag_q <= selRst[`SEL_FLAG_HI:`SEL_FLAG_LO];
                end
                else
                begin
                    if (hit && wStrb_q[1])
                        enable_q <= wData_q[`SEL_EN_HI:`SEL_EN_LO];
                    // RULE_03 event sets flag regardless of enable, set beats clear
                    flag_q <= (flag_q & keep) | srcVec[v];
                end
            end
            assign selFlat[v*16 +: 16] = {enable_q, flag_q};
            // RULE_02 enables mask the flags
            assign vecReq[v] = |(enable_q & flag_q);
        end
    endgenerate

    assign sharedVector0 = vecReq[0];
    assign sharedVector1 = vecReq[1];
    assign sharedVector2 = vecReq[2];
    assign sharedVector3 = vecReq[3];

    // ****************
    // trap flags and arbitration
    // ****************

    reg [15:0] trapFlag_q;
    reg [2:0] pendA_q;
    reg pendB_q;
    reg pendReset_q;
    reg [1:0] activeLvl_q;
    wire [15:0] trapEvt;
    wire [15:0] tfKeep;
    wire resetEvt;
    reg takeNow;
    reg [23:0] vecSel;
    reg [6:0] numSel;
    reg [3:0] prioSel;
    reg [1:0] lvlSel;
    reg [2:0] clrA;
    reg clrB;
    reg clrReset;

    // RULE_10 a distinct flag per class B condition
    assign trapEvt = {nonmaskableReq, stackOverflow, stackUnderflow, 7'h00,
        undefinedOpcode, macInterruption, protectedInstrFault,
        illegalOperand, illegalInstrAccess, illegalExtBus};
    assign resetEvt = softResetReq || watchdogOverflow;
    assign tfKeep = (doWrite && wrIdx == 3'd4) ?
        {wStrb_q[1] ? wData_q[15:8] : 8'hff, wStrb_q[0] ? wData_q[7:0] : 8'hff} : 16'hffff;

    // arbitration; a pending reset is taken whatever is in service, other traps only preempt a lower class
    always @*
    begin
        takeNow = 1'b0;
        vecSel = `VEC_RESET;
        numSel = `NUM_RESET;
        prioSel = `PRIO_TOP;
        lvlSel = activeLvl_q;
        clrA = 3'b000;
        clrB = 1'b0;
        clrReset = 1'b0;
        // RULE_07 resets first, vector zero
        if (pendReset_q)
        begin
            takeNow = 1'b1;
            lvlSel = `LVL_RESET;
            clrReset = 1'b1;
        end
        // RULE_14 nonmaskable, then overflow, then underflow
        else if (pendA_q != 3'b000 && activeLvl_q < `LVL_CLASS_A)
        begin
            takeNow = 1'b1;
            lvlSel = `LVL_CLASS_A;
            // RULE_08 dedicated class A vectors
            if (pendA_q[2])
            begin
                vecSel = `VEC_NONMASKABLE;
                numSel = `NUM_NONMASKABLE;
                clrA = 3'b100;
            end
            else if (pendA_q[1])
            begin
                vecSel = `VEC_STACK_OVER;
                numSel = `NUM_STACK_OVER;
                clrA = 3'b010;
            end
            else
            begin
                vecSel = `VEC_STACK_UNDER;
                numSel = `NUM_STACK_UNDER;
                clrA = 3'b001;
            end
        end
        // RULE_09 one shared class B entry below class A
        else if (pendB_q && activeLvl_q < `LVL_CLASS_B)
        begin
            takeNow = 1'b1;
            lvlSel = `LVL_CLASS_B;
            vecSel = `VEC_CLASS_B;
            numSel = `NUM_CLASS_B;
            clrB = 1'b1;
        end
        // RULE_11 software trap keeps current priority, not while hardware pends
        else if (swTrapReq && activeLvl_q == `LVL_NONE)
        begin
            takeNow = 1'b1;
            vecSel = {15'h0000, swTrapNumber, 2'b00};
            numSel = swTrapNumber;
            prioSel = cpuPriorityLevel;
        end
    end

    // RULE_13 unmaskable flags, pending state and service tracking
    always @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            trapFlag_q <= `TF_RESET;
            pendA_q <= 3'b000;
            pendB_q <= 1'b0;
            pendReset_q <= 1'b0;
            activeLvl_q <= `LVL_NONE;
            trapTake_q <= 1'b0;
            trapVector_q <= `VEC_RESET;
            trapNumber_q <= `NUM_RESET;
            trapPriority_q <= `PRIO_TOP;
        end
        else
        begin
            // flags stay until software writes zero; a new event wins
            trapFlag_q <= (trapFlag_q & tfKeep) | trapEvt;
            pendA_q <= (pendA_q & ~clrA) | trapEvt[15:13];
            pendB_q <= (pendB_q && !clrB) || |(trapEvt & `TF_CLASS_B_MASK);
            pendReset_q <= (pendReset_q && !clrReset) || resetEvt;
            trapTake_q <= takeNow;
            if (takeNow)
            begin
                trapVector_q <= vecSel;
                trapNumber_q <= numSel;
                // RULE_12 hardware entries carry priority 15
                trapPriority_q <= prioSel;
                activeLvl_q <= lvlSel;
            end
            else if (trapReturn)
                activeLvl_q <= `LVL_NONE;
        end
    end

    // hardware trap service holds off standard and event-controller interrupts
    assign standardIrqBlock = (activeLvl_q != `LVL_NONE);

    // ****************
    // system interrupt status and mask
    // ****************

    reg [3:0] irqStatus_q;
    reg [3:0] irqMask_q;
    wire stHit;

    assign stHit = doWrite && (wrIdx == 3'd5) && wStrb_q[0];

    // write one to clear; a vector still requesting sets again at once
    always @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            irqStatus_q <= 4'h0;
            irqMask_q <= 4'h0;
        end
        else
        begin
            irqStatus_q <= (irqStatus_q & ~(stHit ? wData_q[3:0] : 4'h0)) | vecReq;
            if (doWrite && wrIdx == 3'd6 && wStrb_q[0])
                irqMask_q <= wData_q[3:0];
        end
    end

    assign irq = |(irqStatus_q & irqMask_q);

    // ****************
    // read path
    // ****************

    // RULE_04 flag byte readable for source identification
    always @*
    begin
        case (rdIdx)
            3'd0: rdMux = {16'h0000, selFlat[15:0]};
            3'd1: rdMux = {16'h0000, selFlat[31:16]};
            3'd2: rdMux = {16'h0000, selFlat[47:32]};
            3'd3: rdMux = {16'h0000, selFlat[63:48]};
            3'd4: rdMux = {16'h0000, trapFlag_q};
            3'd5: rdMux = {28'h0000000, irqStatus_q};
            3'd6: rdMux = {28'h0000000, irqMask_q};
            default: rdMux = 32'h00000000;
        endcase
    end

    // read answer one cycle after address accept
    always @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rdMux;
            s_axi_rresp <= (rdIdx == 3'd7) ? `RESP_SLVERR : `RESP_OKAY;
        end
        else if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end

endmodule
